// ==== sac_ctrl.sv ====
// Calibration and mode controller for three low-side current-sense amplifiers.
// Assumes pin inputs arrive asynchronously and that the analog front end
// obeys the switch controls it is given.
//
// Chosen here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
module sac_ctrl (
    // Clock, reset and enable.
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    // AXI4-Lite write address and data.
    input wire logic awvalid,
    output logic awready,
    input wire logic [11:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // AXI4-Lite write response.
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // AXI4-Lite read.
    input wire logic arvalid,
    output logic arready,
    input wire logic [11:0] araddr,
    input wire logic [2:0] arprot,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // Analog status and gate-driver pins.
    input wire logic vref_good,
    input wire logic [2:0] gate_drive_window,
    input wire logic [2:0] lowside_on_cmd,
    // Analog controls.
    output sac_pkg::sac_amp_cfg_s amp_cfg,
    output sac_pkg::sac_chan_ctl_s [2:0] chan_ctl
);

    logic aw_have_reg, aw_have_next;
    logic [11:0] awaddr_reg, awaddr_next;
    logic w_have_reg, w_have_next;
    logic [31:0] wdata_reg, wdata_next;
    logic [3:0] wstrb_reg, wstrb_next;
    logic bvalid_reg, bvalid_next;
    logic [1:0] bresp_reg, bresp_next;
    logic rvalid_reg, rvalid_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [1:0] rresp_reg, rresp_next;
    logic [31:0] ctrl_reg, ctrl_next;
    logic [6:0] s1_reg, s2_reg, s3_reg, filt_reg, filt_next;
    logic [2:0] win_prev_reg, req_prev_reg, ds_en_reg, ds_en_next;
    sac_pkg::sac_state_e state_reg, state_next;
    logic [10:0] cnt_reg, cnt_next;
    sac_pkg::sac_amp_cfg_s cfg_reg, cfg_next;
    sac_pkg::sac_chan_ctl_s [2:0] chan_reg, chan_next;
    logic [2:0] man_cal;
    logic [2:0] req, win_fall, lo_on;
    logic vref_ok, sws, self_trim, trimming, running;
    logic aw_take, w_take, do_write;
    logic [11:0] wr_addr;
    logic [31:0] wr_data, wr_mask, status_word;

    // Handshake readies depend only on flip-flops and the enable.
    assign awready = clk_en & ~aw_have_reg & ~bvalid_reg;
    assign wready = clk_en & ~w_have_reg & ~bvalid_reg;
    assign arready = clk_en & ~rvalid_reg;
    assign bvalid = bvalid_reg;
    assign bresp = bresp_reg;
    assign rvalid = rvalid_reg;
    assign rdata = rdata_reg;
    assign rresp = rresp_reg;
    assign amp_cfg = cfg_reg;
    assign chan_ctl = chan_reg;

    // Decoded fields of the control register and the filtered pins.
    assign req = ctrl_reg[sac_pkg::CTRL_REQ_POS +: 3];
    assign sws = ctrl_reg[sac_pkg::CTRL_SWS_POS];
    assign self_trim = ctrl_reg[sac_pkg::CTRL_SELF_TRIM_POS];
    assign vref_ok = filt_reg[0];
    assign lo_on = filt_reg[6:4];
    assign win_fall = win_prev_reg & ~filt_reg[3:1]; // see R13
    assign trimming = (state_reg == sac_pkg::ST_TRIM);
    assign running = (state_reg == sac_pkg::ST_RUN);

    // Status word shows sequencer state and per-channel switch states.
    always_comb begin
        status_word = 32'h00000000;
        status_word[sac_pkg::STAT_TRIM_POS] = trimming;
        status_word[sac_pkg::STAT_READY_POS] = running;
        for (int i = 0; i < 3; i++) begin
            status_word[sac_pkg::STAT_AMP_EN_POS + i] = chan_reg[i].amp_en;
            status_word[sac_pkg::STAT_CAL_POS + i] = chan_reg[i].load_disc;
        end
    end

    // Bus slave: address and data are taken in either order.
    always_comb begin
        aw_take = awvalid & awready;
        w_take = wvalid & wready;
        aw_have_next = aw_have_reg | aw_take;
        awaddr_next = aw_take ? awaddr : awaddr_reg;
        w_have_next = w_have_reg | w_take;
        wdata_next = w_take ? wdata : wdata_reg;
        wstrb_next = w_take ? wstrb : wstrb_reg;
        wr_addr = awaddr_next;
        wr_data = wdata_next;
        wr_mask = {{8{wstrb_next[3]}}, {8{wstrb_next[2]}},
                   {8{wstrb_next[1]}}, {8{wstrb_next[0]}}};
        do_write = aw_have_next & w_have_next & ~bvalid_reg & clk_en;
        bvalid_next = bvalid_reg & ~bready;
        bresp_next = bresp_reg;
        ctrl_next = ctrl_reg;
        if (do_write) begin
            aw_have_next = 1'b0;
            w_have_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = sac_pkg::RESP_OKAY;
            if (wr_addr[11:2] == sac_pkg::CTRL_OFFSET[11:2]) begin
                wr_mask = wr_mask & sac_pkg::CTRL_MASK;
                ctrl_next = (ctrl_reg & ~wr_mask) | (wr_data & wr_mask);
            end else if (wr_addr[11:2] != sac_pkg::STATUS_OFFSET[11:2]) begin
                bresp_next = sac_pkg::RESP_SLVERR;
            end
        end
        rvalid_next = rvalid_reg & ~rready;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        if (arvalid & arready) begin
            rvalid_next = 1'b1;
            rresp_next = sac_pkg::RESP_OKAY;
            if (araddr[11:2] == sac_pkg::CTRL_OFFSET[11:2]) begin
                rdata_next = ctrl_reg;
            end else if (araddr[11:2] == sac_pkg::STATUS_OFFSET[11:2]) begin
                rdata_next = status_word;
            end else begin
                rdata_next = 32'h00000000;
                rresp_next = sac_pkg::RESP_SLVERR;
            end
        end
    end

    // Pin filter: a change counts once the second and third stages agree.
    always_comb begin
        filt_next = (filt_reg & (s2_reg ^ s3_reg)) | (s3_reg & ~(s2_reg ^ s3_reg));
    end

    // Trim sequencer: power-up trim and runtime rerun.
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        case (state_reg)
            sac_pkg::ST_WAIT_REF: begin
                cnt_next = 11'h000;
                if (vref_ok) begin
                    state_next = sac_pkg::ST_TRIM; // see R05
                end
            end
            sac_pkg::ST_TRIM: begin
                cnt_next = cnt_reg + 11'h001;
                if (!vref_ok) begin
                    state_next = sac_pkg::ST_WAIT_REF;
                end else if (cnt_reg == sac_pkg::TRIM_LAST) begin
                    state_next = sac_pkg::ST_RUN; // see R05
                end
            end
            sac_pkg::ST_RUN: begin
                cnt_next = 11'h000;
                if (!vref_ok) begin
                    state_next = sac_pkg::ST_WAIT_REF;
                end else if (self_trim && |(req & ~req_prev_reg)) begin
                    state_next = sac_pkg::ST_TRIM; // see R06
                end
            end
            default: begin
                state_next = sac_pkg::ST_WAIT_REF;
                cnt_next = 11'h000;
            end
        endcase
    end

    // Settings shared by all amplifiers.
    always_comb begin
        cfg_next.gain = trimming ? sac_pkg::GAIN_MAX
                                 : ctrl_reg[sac_pkg::CTRL_GAIN_POS +: 2]; // see R01, R07
        cfg_next.unidir = ctrl_reg[sac_pkg::CTRL_HALVE_POS]; // see R02
        cfg_next.lowside_monitor_ref_select_neg = sws | ctrl_reg[sac_pkg::CTRL_LOWSIDE_MONITOR_REF_SELECT_POS]; // see R09, R12
        cfg_next.trim_active = trimming;
        cfg_next.ready = running;
    end

    // Per-channel switch controls.
    for (genvar g = 0; g < 3; g++) begin : g_chan
        always_comb begin
            man_cal[g] = running & ~self_trim & req[g]; // see R03, R14
            ds_en_next[g] = ds_en_reg[g];
            if (!sws || !lo_on[g]) begin
                ds_en_next[g] = 1'b0;
            end else if (win_fall[g]) begin
                ds_en_next[g] = 1'b1; // see R10
            end
            chan_next[g].in_short = trimming | man_cal[g]
                                  | (sws & ~lo_on[g]); // see R03, R11
            chan_next[g].load_disc = trimming | man_cal[g]; // see R03
            chan_next[g].pos_switch_node = sws; // see R08
            // The next enable is used so a low-side off command drops the
            // amplifier in the same cycle that its inputs are shorted.
            chan_next[g].amp_en = running & (~sws | ds_en_next[g]); // see R10
        end
    end

    // All state registers, frozen while the enable is low.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_reg <= 1'b0;
            awaddr_reg <= 12'h000;
            w_have_reg <= 1'b0;
            wdata_reg <= 32'h00000000;
            wstrb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= 2'h0;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
            rresp_reg <= 2'h0;
            ctrl_reg <= sac_pkg::CTRL_RESET;
            s1_reg <= 7'h00;
            s2_reg <= 7'h00;
            s3_reg <= 7'h00;
            filt_reg <= 7'h00;
            win_prev_reg <= 3'h0;
            req_prev_reg <= 3'h0;
            ds_en_reg <= 3'h0;
            state_reg <= sac_pkg::ST_WAIT_REF;
            cnt_reg <= 11'h000;
            cfg_reg <= '0;
            chan_reg <= '0;
        end else if (clk_en) begin
            aw_have_reg <= aw_have_next;
            awaddr_reg <= awaddr_next;
            w_have_reg <= w_have_next;
            wdata_reg <= wdata_next;
            wstrb_reg <= wstrb_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
            ctrl_reg <= ctrl_next;
            s1_reg <= {lowside_on_cmd, gate_drive_window, vref_good};
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            filt_reg <= filt_next;
            win_prev_reg <= filt_reg[3:1];
            req_prev_reg <= req;
            ds_en_reg <= ds_en_next;
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            cfg_reg <= cfg_next;
            chan_reg <= chan_next;
        end
    end

    // Checks on the shared settings, the trim sequencer and the channel switch controls.
    property p_gain_max;
        @(posedge aclk) disable iff (!aresetn)
        clk_en && trimming |=> cfg_reg.gain == 2'h3;
    endproperty
    a_gain_max: assert property (p_gain_max) else $error("gain not maximal in trim"); // see R07

    property p_gain_prog;
        @(posedge aclk) disable iff (!aresetn)
        clk_en && running |=> cfg_reg.gain == $past(ctrl_reg[1:0]);
    endproperty
    a_gain_prog: assert property (p_gain_prog) else $error("programmed gain lost"); // see R01

    property p_unidir;
        @(posedge aclk) disable iff (!aresetn)
        clk_en |=> cfg_reg.unidir == $past(ctrl_reg[2]);
    endproperty
    a_unidir: assert property (p_unidir) else $error("unidirectional select lost"); // see R02

    property p_lowside_monitor_ref_select;
        @(posedge aclk) disable iff (!aresetn)
        clk_en && sws |=> cfg_reg.lowside_monitor_ref_select_neg;
    endproperty
    a_lowside_monitor_ref_select: assert property (p_lowside_monitor_ref_select) else $error("monitor reference not forced"); // see R09

    property p_manual_cal;
        @(posedge aclk) disable iff (!aresetn)
        clk_en && running && !self_trim && !sws && req[0]
            |=> chan_reg[0].in_short && chan_reg[0].load_disc;
    endproperty
    a_manual_cal: assert property (p_manual_cal) else $error("manual calibration missing"); // see R03

    property p_cal_release;
        @(posedge aclk) disable iff (!aresetn)
        clk_en && running && !req[1] |=> !chan_reg[1].load_disc;
    endproperty
    a_cal_release: assert property (p_cal_release) else $error("calibration not released"); // see R14

    property p_self_trim;
        @(posedge aclk) disable iff (!aresetn)
        clk_en && running && vref_ok && self_trim && (req[2] && !req_prev_reg[2])
            |=> trimming;
    endproperty
    a_self_trim: assert property (p_self_trim) else $error("runtime trim not started"); // see R06

    property p_trim_len;
        @(posedge aclk) disable iff (!aresetn)
        clk_en && trimming && state_next == sac_pkg::ST_RUN
            |-> cnt_reg == 11'd1249;
    endproperty
    a_trim_len: assert property (p_trim_len) else $error("trim length wrong"); // see R05

    property p_switch_node;
        @(posedge aclk) disable iff (!aresetn)
        clk_en |=> chan_reg[0].pos_switch_node == $past(sws);
    endproperty
    a_switch_node: assert property (p_switch_node) else $error("input routing wrong"); // see R08

    property p_ds_enable;
        @(posedge aclk) disable iff (!aresetn)
        clk_en && running && vref_ok && sws && lo_on[0] && win_fall[0]
            ##1 clk_en && running && sws && lo_on[0] |=> chan_reg[0].amp_en;
    endproperty
    a_ds_enable: assert property (p_ds_enable) else $error("amplifier not enabled"); // see R10

    property p_ds_short;
        @(posedge aclk) disable iff (!aresetn)
        clk_en && sws && !lo_on[1] |=> chan_reg[1].in_short && !chan_reg[1].amp_en;
    endproperty
    a_ds_short: assert property (p_ds_short) else $error("inputs not shorted"); // see R11

    // Main scenarios.
    c_trim_done: cover property (@(posedge aclk) disable iff (!aresetn)
        trimming ##1 running);
    c_manual: cover property (@(posedge aclk) disable iff (!aresetn)
        running && man_cal[0]);
    c_ds_on: cover property (@(posedge aclk) disable iff (!aresetn)
        sws && chan_reg[2].amp_en);

endmodule // sac_ctrl

// ==== sac_ctrl_test.sv ====
// Self-checking bench for the amplifier calibration controller.
// Assumes a 25 MHz clock and the register map of the controller package.
`timescale 1ns/1ps
module sac_ctrl_test;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic vref_good = 1'b0;
    logic [2:0] lo_req = 3'h0;
    logic [11:0] awaddr = 12'h000;
    logic [11:0] araddr = 12'h000;
    logic [31:0] wdata = 32'h00000000;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [2:0] gdw, lo_on;
    sac_pkg::sac_amp_cfg_s amp_cfg;
    sac_pkg::sac_chan_ctl_s [2:0] chan_ctl;
    int mismatches = 0;
    int n_compared = 0;

    // Clock of 40 ns period.
    always #20 aclk = ~aclk;

    sac_ctrl i_sac_ctrl (
        .aclk(aclk), .aresetn(aresetn), .clk_en(1'b1),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .awprot(3'h0), .wvalid(wvalid), .wready(wready),
        .wdata(wdata), .wstrb(4'hF), .bvalid(bvalid), .bready(bready),
        .bresp(bresp), .arvalid(arvalid), .arready(arready),
        .araddr(araddr), .arprot(3'h0), .rvalid(rvalid),
        .rready(rready), .rdata(rdata), .rresp(rresp),
        .vref_good(vref_good), .gate_drive_window(gdw),
        .lowside_on_cmd(lo_on), .amp_cfg(amp_cfg), .chan_ctl(chan_ctl)
    );

    sac_gate_model i_sac_gate_model (
        .aclk(aclk), .lo_req(lo_req),
        .gate_drive_window(gdw), .lowside_on_cmd(lo_on)
    );

    // Gathers one switch field of all three channels, bit k of the struct.
    function automatic logic [2:0] fld(input int k);
        for (int i = 0; i < 3; i++) fld[i] = chan_ctl[i][k];
    endfunction

    task automatic wrap_up();
        if (mismatches == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // A wait that runs out of its bound ends the run as a mismatch.
    task automatic hang(input string nm);
        chk(nm, 32'h1, 32'h0);
        wrap_up();
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask

    // Write cycle; one spare edge follows so no signal is set twice at once.
    task automatic wchk(input logic [11:0] a, input logic [31:0] d,
                        input logic [1:0] er);
        int n;
        n = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 40);
        if (bvalid !== 1'b1) hang("write");
        bready <= 1'b0;
        chk("bresp", 32'(er), 32'(bresp));
        @(posedge aclk);
    endtask

    // Read cycle compared against an expected word and answer code.
    task automatic rchk(input logic [11:0] a, input logic [31:0] e,
                        input logic [1:0] er);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 40);
        if (rvalid !== 1'b1) hang("read");
        rready <= 1'b0;
        chk("rdata", e, rdata);
        chk("rresp", 32'(er), 32'(rresp));
        @(posedge aclk);
    endtask

    task automatic wait_trim(input logic w, input int lim);
        int n;
        n = 0;
        while (amp_cfg.trim_active !== w && n < lim) begin
            tick(1);
            n++;
        end
        if (n >= lim) hang("trim wait");
    endtask

    // Main sequence.
    initial begin
        logic [31:0] v;
        int n;
        tick(2);
        aresetn <= 1'b1;
        rchk(sac_pkg::CTRL_OFFSET, sac_pkg::CTRL_RESET, sac_pkg::RESP_OKAY);
        rchk(sac_pkg::STATUS_OFFSET, 32'h0, sac_pkg::RESP_OKAY);
        rchk(12'h008, 32'h0, sac_pkg::RESP_SLVERR);
        wchk(12'h00C, 32'hFFFFFFFF, sac_pkg::RESP_SLVERR);
        wchk(sac_pkg::STATUS_OFFSET, 32'hFFFFFFFF, sac_pkg::RESP_OKAY);
        rchk(sac_pkg::STATUS_OFFSET, 32'h0, sac_pkg::RESP_OKAY);
        // Power-up trim once the reference is good.
        vref_good <= 1'b1;
        wait_trim(1'b1, 20);
        chk("trim gain", 32'(sac_pkg::GAIN_MAX), 32'(amp_cfg.gain));
        chk("trim short", 32'h7, 32'(fld(2)));
        chk("trim amp_en", 32'h0, 32'(fld(3)));
        n = 0;
        while (amp_cfg.trim_active === 1'b1 && n < 2000) begin
            tick(1);
            n++;
        end
        chk("trim cycles", sac_pkg::TRIM_CYCLES_INT, 32'(n));
        tick(2);
        rchk(sac_pkg::STATUS_OFFSET, 32'h72, sac_pkg::RESP_OKAY);
        chk("ready", 32'h1, 32'(amp_cfg.ready));
        chk("trim off", 32'h0, 32'(amp_cfg.trim_active));
        // Every gain code, with reference and monitor selects alongside.
        for (int g = 0; g < 4; g++) begin
            v = 32'(g) | (32'(g & 1) << 2) | (32'(g >> 1) << 5);
            wchk(sac_pkg::CTRL_OFFSET, v, sac_pkg::RESP_OKAY);
            tick(2);
            chk("gain", 32'(g), 32'(amp_cfg.gain));
            chk("unidir", 32'(g & 1), 32'(amp_cfg.unidir));
            chk("lowside_monitor_ref_select", 32'(g >> 1), 32'(amp_cfg.lowside_monitor_ref_select_neg));
            rchk(sac_pkg::CTRL_OFFSET, v, sac_pkg::RESP_OKAY);
        end
        // Manual calibration per channel while the bridges keep switching.
        for (int i = 0; i < 3; i++) begin
            lo_req <= 3'(i + 1);
            v = 32'h100 << i;
            wchk(sac_pkg::CTRL_OFFSET, v, sac_pkg::RESP_OKAY);
            tick(2);
            chk("cal short", 32'h1 << i, 32'(fld(2)));
            chk("cal load", 32'h1 << i, 32'(fld(1)));
            rchk(sac_pkg::STATUS_OFFSET, 32'h72 | v,
                 sac_pkg::RESP_OKAY);
        end
        wchk(sac_pkg::CTRL_OFFSET, 32'h0, sac_pkg::RESP_OKAY);
        tick(2);
        chk("cal off", 32'h0, 32'(fld(2)));
        chk("cal load off", 32'h0, 32'(fld(1)));
        // Run-time trim rerun at low programmed gain.
        wchk(sac_pkg::CTRL_OFFSET, 32'h8, sac_pkg::RESP_OKAY);
        wchk(sac_pkg::CTRL_OFFSET, 32'h208, sac_pkg::RESP_OKAY);
        wait_trim(1'b1, 10);
        chk("self gain", 32'(sac_pkg::GAIN_MAX), 32'(amp_cfg.gain));
        chk("self load", 32'h7, 32'(fld(1)));
        wait_trim(1'b0, 1300);
        tick(2);
        chk("gain back", 32'h0, 32'(amp_cfg.gain));
        // Drain-source sense mode with the monitor select left clear.
        lo_req <= 3'h0;
        wchk(sac_pkg::CTRL_OFFSET, 32'h10, sac_pkg::RESP_OKAY);
        tick(8);
        chk("pos sw", 32'h7, 32'(fld(0)));
        chk("ref neg", 32'h1, 32'(amp_cfg.lowside_monitor_ref_select_neg));
        chk("off short", 32'h7, 32'(fld(2)));
        chk("off amp", 32'h0, 32'(fld(3)));
        lo_req <= 3'h7;
        tick(8);
        chk("win amp", 32'h0, 32'(fld(3)));
        tick(14);
        chk("ds amp", 32'h7, 32'(fld(3)));
        chk("ds short", 32'h0, 32'(fld(2)));
        lo_req <= 3'h0;
        tick(8);
        chk("off again", 32'h7, 32'(fld(2)));
        wrap_up();
    end
endmodule // sac_ctrl_test

// ==== sac_gate_model.sv ====
// Gate-driver side model that switches the three low-side transistors.
// Assumes the bench commands each low-side switch through lo_req.
`timescale 1ns/1ps
module sac_gate_model #(
    parameter int WIN = 12
) (
    // Clock.
    input wire logic aclk,
    // Bench commands.
    input wire logic [2:0] lo_req,
    // Driver pins.
    output logic [2:0] gate_drive_window,
    output logic [2:0] lowside_on_cmd
);
    int cnt [3];

    // Both pins start low, so nothing is switching at time zero.
    initial begin
        gate_drive_window = 3'h0;
        lowside_on_cmd = 3'h0;
    end

    // Each command edge opens a strong-drive window of WIN cycles.
    always @(posedge aclk) begin
        for (int i = 0; i < 3; i++) begin
            if (lo_req[i] !== lowside_on_cmd[i]) begin
                lowside_on_cmd[i] <= lo_req[i];
                gate_drive_window[i] <= 1'b1;
                cnt[i] <= WIN;
            end else if (cnt[i] > 0) begin
                cnt[i] <= cnt[i] - 1;
                gate_drive_window[i] <= (cnt[i] > 1);
            end
        end
    end
endmodule // sac_gate_model

// ==== sac_pkg.sv ====
// Constants, types and register layout for the current-sense amplifier
// calibration controller.
// Assumes a 25 MHz aclk and a 32-bit AXI4-Lite register bus.
// Operation
// R01 - The amplifier gain is one of 5, 10, 20 or 40 V/V, chosen by amp_gain.
// R02 - Setting the reference halving select makes every amplifier unidirectional.
// R03 - A set channel_offset_trim_request bit in manual mode shorts only that channel's inputs and drops its load.
// R04 - The controller may ask for calibration at any time, best while the bridges are off.
// R05 - Automatic trim starts when the reference is good and the outputs are usable 50 us later.
// R06 - With runtime_self_trim_enable set, a trim request reruns the automatic trim instead.
// R07 - During automatic trim every amplifier runs at the highest gain.
// R08 - With switch_voltage_sense_select set, the positive input goes through the clamp to switch_node.
// R09 - With switch_voltage_sense_select set, the low-side monitor always references sense_neg_input.
// R10 - In drain-source mode the amplifier is enabled at the end of gate_drive_window.
// R11 - In drain-source mode a low-side off command shorts that channel's inputs.
// R12 - lowside_monitor_ref_select picks the low-side monitor reference only.
// R13 - gate_drive_window marks the strong drive interval after each switching edge.
// R14 - Manual calibration lasts as long as the request bit is set.
package sac_pkg;

    // Clock and trim timing.
    localparam int unsigned CLK_MHZ = 25;
    localparam int unsigned TRIM_TIME_NS = 50000;
    localparam int unsigned TRIM_CYCLES_INT = (TRIM_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam logic [10:0] TRIM_LAST = 11'(TRIM_CYCLES_INT - 1);

    // Register byte offsets.
    localparam logic [11:0] CTRL_OFFSET = 12'h000;
    localparam logic [11:0] STATUS_OFFSET = 12'h004;

    // Control register fields.
    localparam int unsigned CTRL_GAIN_POS = 0;
    localparam int unsigned CTRL_HALVE_POS = 2;
    localparam int unsigned CTRL_SELF_TRIM_POS = 3;
    localparam int unsigned CTRL_SWS_POS = 4;
    localparam int unsigned CTRL_LOWSIDE_MONITOR_REF_SELECT_POS = 5;
    localparam int unsigned CTRL_REQ_POS = 8;
    localparam logic [31:0] CTRL_MASK = 32'h0000073F;
    localparam logic [31:0] CTRL_RESET = 32'h00000000;

    // Status register fields.
    localparam int unsigned STAT_TRIM_POS = 0;
    localparam int unsigned STAT_READY_POS = 1;
    localparam int unsigned STAT_AMP_EN_POS = 4;
    localparam int unsigned STAT_CAL_POS = 8;

    // Gain codes and bus answers.
    localparam logic [1:0] GAIN_MAX = 2'h3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Trim sequencer states, Gray coded along the power-up path.
    typedef enum logic [1:0] {
        ST_WAIT_REF = 2'b00,
        ST_TRIM = 2'b01,
        ST_RUN = 2'b11
    } sac_state_e;

    // Settings common to all three amplifiers.
    typedef struct packed {
        logic [1:0] gain;
        logic unidir;
        logic lowside_monitor_ref_select_neg;
        logic trim_active;
        logic ready;
    } sac_amp_cfg_s;

    // Switch controls of one amplifier channel.
    typedef struct packed {
        logic amp_en;
        logic in_short;
        logic load_disc;
        logic pos_switch_node;
    } sac_chan_ctl_s;

endpackage
